// ### core/msx_exec_alu.sv
// msx_exec_alu: combinational datapath for swap, skip tests and XOR forms.
// assumes operands are stable in the cycle the instruction is issued.
`timescale 1ns/1ns
`default_nettype none
module msx_exec_alu (
  // operands
  input wire msx_exec_pkg::msx_instr_t i_instr,
  input wire logic [msx_exec_pkg::MSX_DATA_W-1:0] i_acc,
  // outcome
  output msx_exec_pkg::msx_alu_res_t o_res
);
  import msx_exec_pkg::*;

  logic [MSX_DATA_W-1:0] xor_val;
  logic [MSX_DATA_W-1:0] swapped;
  logic data_zero;

  // shared terms
  assign swapped = {i_instr.mem_data[3:0], i_instr.mem_data[7:4]}; // RULE1
  assign data_zero = (i_instr.mem_data == MSX_ZERO_BYTE);
  assign xor_val = i_acc ^ ((i_instr.op == OP_XOR_IMMEDIATE) ? i_instr.literal
                                                            : i_instr.mem_data);

  // per-instruction effects; anything not listed leaves all state alone
  always_comb begin
    o_res = '0;
    o_res.zero_val = (xor_val == MSX_ZERO_BYTE); // RULE11
    o_res.zero_we = msx_is_xor(i_instr.op);
    unique case (i_instr.op)
      OP_NIBBLE_SWAP_TO_ACC: begin
        o_res.acc_we = 1'b1; // RULE1
        o_res.acc_val = swapped;
      end
      OP_SKIP_WHEN_ZERO: begin
        o_res.skip = data_zero; // RULE2
      end
      OP_COPY_AND_SKIP_ZERO: begin
        o_res.acc_we = 1'b1; // RULE3
        o_res.acc_val = i_instr.mem_data;
        o_res.skip = data_zero;
      end
      OP_SKIP_BIT_CLEAR: begin
        o_res.skip = ~i_instr.mem_data[i_instr.bit_idx]; // RULE4
      end
      OP_XOR_ACC_MEM, OP_XOR_IMMEDIATE: begin
        o_res.acc_we = 1'b1; // RULE7 RULE9
        o_res.acc_val = xor_val;
      end
      OP_XOR_INTO_MEMORY: begin
        o_res.mem_we = 1'b1; // RULE8
        o_res.mem_val = xor_val;
      end
      default: begin
        o_res.zero_we = 1'b0;
      end
    endcase
  end

endmodule : msx_exec_alu
`default_nettype wire

// ### core/msx_exec_pkg.sv
// msx_exec_pkg: shared types, widths and constants for the swap, skip,
// table-read and exclusive-OR execution block.
// assumes a single 125 MHz clock; program memory words are 14 bits wide.
package msx_exec_pkg;

  // data and program memory geometry
  localparam int unsigned MSX_DATA_W = 8;
  localparam int unsigned MSX_ROM_W = 14;
  localparam int unsigned MSX_PTR_W = 8;
  localparam int unsigned MSX_PAGE_W = 3;
  localparam int unsigned MSX_ROM_AW = MSX_PAGE_W + MSX_PTR_W;
  localparam int unsigned MSX_HIGH_W = MSX_ROM_W - MSX_DATA_W;
  localparam logic [MSX_PAGE_W-1:0] MSX_LAST_PAGE = 3'h7;

  // reset values
  localparam logic [MSX_DATA_W-1:0] MSX_ACC_RST = 8'h00;
  localparam logic [MSX_HIGH_W-1:0] MSX_HIGH_RST = 6'h00;
  localparam logic [MSX_DATA_W-1:0] MSX_ZERO_BYTE = 8'h00;

  // timing: instruction cycles taken, in clock cycles
  localparam int unsigned MSX_SKIP_CYCLES = 2;
  localparam int unsigned MSX_PLAIN_CYCLES = 1;
  localparam int unsigned MSX_TABLE_CYCLES = 2;

  // instructions handled by this block
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_NIBBLE_SWAP_TO_ACC = 4'h1,
    OP_SKIP_WHEN_ZERO = 4'h2,
    OP_COPY_AND_SKIP_ZERO = 4'h3,
    OP_SKIP_BIT_CLEAR = 4'h4,
    OP_TABLE_READ_CURRENT_PAGE = 4'h5,
    OP_TABLE_READ_LAST_PAGE = 4'h6,
    OP_XOR_ACC_MEM = 4'h7,
    OP_XOR_INTO_MEMORY = 4'h8,
    OP_XOR_IMMEDIATE = 4'h9
  } msx_op_t;

  // one issued instruction with its operands
  typedef struct packed {
    msx_op_t op;
    logic [MSX_DATA_W-1:0] mem_data;
    logic [2:0] bit_idx;
    logic [MSX_DATA_W-1:0] literal;
  } msx_instr_t;

  // combinational outcome of one instruction
  typedef struct packed {
    logic acc_we;
    logic [MSX_DATA_W-1:0] acc_val;
    logic mem_we;
    logic [MSX_DATA_W-1:0] mem_val;
    logic zero_we;
    logic zero_val;
    logic skip;
  } msx_alu_res_t;

  // execution sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TBL_WAIT = 3'b010,
    ST_DUMMY = 3'b100
  } msx_fsm_t;

  // exclusive-OR forms touch the zero flag
  function automatic logic msx_is_xor(input msx_op_t op);
    return (op == OP_XOR_ACC_MEM) || (op == OP_XOR_INTO_MEMORY) || (op == OP_XOR_IMMEDIATE);
  endfunction : msx_is_xor

  // table reads go to program memory
  function automatic logic msx_is_table(input msx_op_t op);
    return (op == OP_TABLE_READ_CURRENT_PAGE) || (op == OP_TABLE_READ_LAST_PAGE);
  endfunction : msx_is_table

endpackage : msx_exec_pkg

// ### core/msx_exec_unit.sv
// msx_exec_unit: executes nibble swap, zero/bit skips, table reads and XOR.
// assumes the decode stage holds the data memory address while o_ready is low
// and program memory drives the word while o_rom_rd is high; it is taken at that cycle's end.
//
// Summary of operation
// RULE1 - swap nibbles of data byte into accumulator, memory untouched
// RULE2 - skip when byte zero: flush prefetched word, dummy cycle, two cycles
// RULE3 - copy byte to accumulator; skip with dummy cycle if it is zero
// RULE4 - skip when selected bit clear: flush, dummy cycle; else one cycle
// RULE5 - current-page table read: low byte to memory, high bits to high register
// RULE6 - last-page table read: same transfer from final program page
// RULE7 - xor accumulator with data byte into accumulator, zero flag only
// RULE8 - xor data byte with accumulator back into memory, zero flag only
// RULE9 - xor literal with accumulator into accumulator, zero flag only
// RULE10 - swap, skip and table reads leave all status flags unchanged
// RULE11 - zero flag set when xor result is zero, else cleared
`timescale 1ns/1ns
`default_nettype none
module msx_exec_unit (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // instruction issue from decode
  input wire logic i_issue,
  input wire msx_exec_pkg::msx_instr_t i_instr,
  input wire logic [msx_exec_pkg::MSX_PTR_W-1:0] i_table_pointer_reg,
  input wire logic [msx_exec_pkg::MSX_PAGE_W-1:0] i_pc_page,
  output logic o_ready,
  // program memory read port
  output logic o_rom_rd,
  output logic [msx_exec_pkg::MSX_ROM_AW-1:0] o_rom_addr,
  input wire logic [msx_exec_pkg::MSX_ROM_W-1:0] i_rom_data,
  // data memory write port
  output logic o_mem_we,
  output logic [msx_exec_pkg::MSX_DATA_W-1:0] o_mem_wdata,
  // pipeline control
  output logic o_flush,
  // architectural state
  output logic [msx_exec_pkg::MSX_DATA_W-1:0] o_acc,
  output logic o_zero,
  output logic o_zero_we,
  output logic [msx_exec_pkg::MSX_HIGH_W-1:0] o_table_high_byte_reg
);
  import msx_exec_pkg::*;

  // all state of the unit in one record
  typedef struct packed {
    msx_fsm_t state;
    logic [MSX_DATA_W-1:0] acc;
    logic zero;
    logic zero_we;
    logic [MSX_HIGH_W-1:0] high;
    logic mem_we;
    logic [MSX_DATA_W-1:0] mem_wdata;
    logic flush;
    logic rom_rd;
    logic [MSX_ROM_AW-1:0] rom_addr;
  } msx_regs_t;

  msx_regs_t st_reg;
  msx_regs_t st_next;
  msx_alu_res_t alu_res;
  logic accept;

  // datapath for the single-cycle forms
  msx_exec_alu u_alu (
    .i_instr(i_instr),
    .i_acc(st_reg.acc),
    .o_res(alu_res)
  );

  // issue is only taken in the idle state, so dummy and table cycles stall decode
  assign o_ready = (st_reg.state == ST_IDLE);
  assign accept = i_issue && o_ready;

  // next-state logic; strobes are cleared each cycle so they last one clock
  always_comb begin
    st_next = st_reg;
    st_next.mem_we = 1'b0;
    st_next.flush = 1'b0;
    st_next.rom_rd = 1'b0;
    st_next.zero_we = 1'b0;
    unique case (st_reg.state)
      ST_IDLE: begin
        if (accept) begin
          if (msx_is_table(i_instr.op)) begin
            // pointer picks the word; page is the current one or the last
            st_next.rom_rd = 1'b1;
            st_next.rom_addr = {(i_instr.op == OP_TABLE_READ_LAST_PAGE) ? MSX_LAST_PAGE // RULE6
                                                                      : i_pc_page, // RULE5
                                i_table_pointer_reg};
            st_next.state = ST_TBL_WAIT;
          end else begin
            if (alu_res.acc_we) begin
              st_next.acc = alu_res.acc_val; // RULE1 RULE3 RULE7 RULE9
            end
            st_next.mem_we = alu_res.mem_we; // RULE8
            st_next.mem_wdata = alu_res.mem_val;
            // only the xor forms touch the flag; the rest keep it as it was
            if (alu_res.zero_we) begin
              st_next.zero = alu_res.zero_val; // RULE10 RULE11
            end
            st_next.zero_we = alu_res.zero_we;
            if (alu_res.skip) begin
              st_next.flush = 1'b1; // RULE2 RULE3 RULE4
              st_next.state = ST_DUMMY;
            end
          end
        end
      end
      ST_TBL_WAIT: begin
        // program word arrives now; split it between memory and the high register
        st_next.mem_we = 1'b1; // RULE5 RULE6
        st_next.mem_wdata = i_rom_data[MSX_DATA_W-1:0];
        st_next.high = i_rom_data[MSX_ROM_W-1:MSX_DATA_W];
        st_next.state = ST_IDLE;
      end
      ST_DUMMY: begin
        st_next.state = ST_IDLE; // RULE2
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '{state: ST_IDLE, acc: MSX_ACC_RST, zero: 1'b0, zero_we: 1'b0,
                  high: MSX_HIGH_RST, mem_we: 1'b0, mem_wdata: MSX_ZERO_BYTE,
                  flush: 1'b0, rom_rd: 1'b0, rom_addr: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign o_rom_rd = st_reg.rom_rd;
  assign o_rom_addr = st_reg.rom_addr;
  assign o_mem_we = st_reg.mem_we;
  assign o_mem_wdata = st_reg.mem_wdata;
  assign o_flush = st_reg.flush;
  assign o_acc = st_reg.acc;
  assign o_zero = st_reg.zero;
  assign o_zero_we = st_reg.zero_we;
  assign o_table_high_byte_reg = st_reg.high;

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_swap_acc: assert property ( // RULE1
    accept && i_instr.op == OP_NIBBLE_SWAP_TO_ACC |=>
      o_acc == {$past(i_instr.mem_data[3:0]), $past(i_instr.mem_data[7:4])} && !o_mem_we
  ) else $error("swap did not place exchanged nibbles");

  chk_skip_zero: assert property ( // RULE2
    accept && i_instr.op == OP_SKIP_WHEN_ZERO && i_instr.mem_data == MSX_ZERO_BYTE |=>
      o_flush && !o_ready ##1 o_ready && !o_flush
  ) else $error("zero byte skip not two cycles");

  chk_noskip_plain: assert property ( // RULE2
    accept && i_instr.op == OP_SKIP_WHEN_ZERO && i_instr.mem_data != MSX_ZERO_BYTE |=>
      !o_flush && o_ready
  ) else $error("nonzero byte skipped");

  chk_copy_skip: assert property ( // RULE3
    accept && i_instr.op == OP_COPY_AND_SKIP_ZERO |=>
      o_acc == $past(i_instr.mem_data) && o_flush == (o_acc == MSX_ZERO_BYTE)
  ) else $error("copy and skip wrong");

  chk_bit_skip: assert property ( // RULE4
    accept && i_instr.op == OP_SKIP_BIT_CLEAR |=>
      o_flush == !$past(i_instr.mem_data[i_instr.bit_idx]) && o_ready == !o_flush
  ) else $error("bit skip decision wrong");

  chk_table_current: assert property ( // RULE5
    accept && i_instr.op == OP_TABLE_READ_CURRENT_PAGE |=>
      o_rom_rd && o_rom_addr == {$past(i_pc_page), $past(i_table_pointer_reg)}
      ##1 o_mem_we && o_mem_wdata == $past(i_rom_data[7:0])
      && o_table_high_byte_reg == $past(i_rom_data[13:8]) && o_ready
  ) else $error("current page table read wrong");

  chk_table_last: assert property ( // RULE6
    accept && i_instr.op == OP_TABLE_READ_LAST_PAGE |=>
      o_rom_rd && o_rom_addr == {MSX_LAST_PAGE, $past(i_table_pointer_reg)}
      ##1 o_mem_we && o_mem_wdata == $past(i_rom_data[7:0])
      && o_table_high_byte_reg == $past(i_rom_data[13:8]) && o_ready
  ) else $error("last page table read wrong");

  // an issue offered during a dummy or table-wait cycle must leave no trace
  chk_busy_ignored: assert property ( // RULE2
    !o_ready |=> $stable(o_acc) && $stable(o_zero) && !o_flush && !o_rom_rd && !o_zero_we
  ) else $error("instruction taken while busy");

  chk_xor_single: assert property ( // RULE7
    accept && msx_is_xor(i_instr.op) |=> o_ready && !o_flush && !o_rom_rd
  ) else $error("xor did not finish in one cycle");

  chk_xor_acc: assert property ( // RULE7
    accept && i_instr.op == OP_XOR_ACC_MEM |=>
      o_acc == ($past(o_acc) ^ $past(i_instr.mem_data)) && o_zero_we && !o_mem_we
  ) else $error("xor into accumulator wrong");

  chk_xor_memory: assert property ( // RULE8
    accept && i_instr.op == OP_XOR_INTO_MEMORY |=>
      o_mem_we && o_mem_wdata == ($past(o_acc) ^ $past(i_instr.mem_data)) && $stable(o_acc)
  ) else $error("xor into memory wrong");

  chk_xor_literal: assert property ( // RULE9
    accept && i_instr.op == OP_XOR_IMMEDIATE |=>
      o_acc == ($past(o_acc) ^ $past(i_instr.literal)) && o_zero_we
  ) else $error("xor with literal wrong");

  chk_flags_kept: assert property ( // RULE10
    accept && !msx_is_xor(i_instr.op) |=> $stable(o_zero) && !o_zero_we
  ) else $error("flag changed by non xor instruction");

  chk_zero_flag: assert property ( // RULE11
    o_zero_we |-> o_zero == ((o_mem_we ? o_mem_wdata : o_acc) == MSX_ZERO_BYTE)
  ) else $error("zero flag disagrees with result");

endmodule : msx_exec_unit
`default_nettype wire

// ### dv/test_mcu_swap_skip_tblrd_xor_exec.sv
// test_mcu_swap_skip_tblrd_xor_exec: self-checking bench for msx_exec_unit.
// assumes the bench plays decode and program memory; an integer model predicts each result.
`timescale 1ns/1ns
`default_nettype none
module test_mcu_swap_skip_tblrd_xor_exec;
  import msx_exec_pkg::*;
  // stimulus, all given a value at time zero
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_issue = 1'b0;
  msx_instr_t i_instr = '0;
  logic [MSX_PTR_W-1:0] i_table_pointer_reg = 8'h00;
  logic [MSX_PAGE_W-1:0] i_pc_page = 3'h0;
  logic [MSX_ROM_W-1:0] i_rom_data = 14'h0000;
  // observed outputs
  logic o_ready, o_rom_rd, o_mem_we, o_flush, o_zero, o_zero_we;
  logic [MSX_ROM_AW-1:0] o_rom_addr;
  logic [MSX_DATA_W-1:0] o_mem_wdata, o_acc;
  logic [MSX_HIGH_W-1:0] o_table_high_byte_reg;
  // model state and counters
  int m_acc = 0;
  int m_zero = 0;
  int err_count = 0;
  int checks = 0;

  msx_exec_unit uut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_issue(i_issue), .i_instr(i_instr),
    .i_table_pointer_reg(i_table_pointer_reg), .i_pc_page(i_pc_page), .o_ready(o_ready),
    .o_rom_rd(o_rom_rd), .o_rom_addr(o_rom_addr), .i_rom_data(i_rom_data),
    .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_flush(o_flush), .o_acc(o_acc),
    .o_zero(o_zero), .o_zero_we(o_zero_we), .o_table_high_byte_reg(o_table_high_byte_reg)
  );

  // 125 MHz clock
  always #4 i_ref_clk = ~i_ref_clk;

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // case equality, so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // issue at a falling edge, check one cycle later; i_issue is left high so the next
  // call can follow back to back without a second write in the same time step
  task automatic run(input logic [3:0] op, input logic [7:0] d, input logic [2:0] b,
                     input logic [7:0] lit);
    logic [13:0] w;
    logic [2:0] pg;
    logic [7:0] pt;
    int r, zw, mw, sk, tb, n;
    w = 14'($urandom);
    pg = 3'($urandom);
    pt = 8'($urandom);
    r = m_acc ^ d;
    zw = 0;
    mw = 0;
    sk = 0;
    tb = 0;
    n = 0;
    while (o_ready !== 1'b1 && n < 20) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      close_out();
    end
    i_issue = 1'b1;
    i_pc_page = pg;
    i_table_pointer_reg = pt;
    i_instr = '{msx_op_t'(op), d, b, lit};
    case (op)
      4'h1: m_acc = {d[3:0], d[7:4]};
      4'h2: sk = (d == 8'h00);
      4'h3: begin
        m_acc = d;
        sk = (d == 8'h00);
      end
      4'h4: sk = !d[b];
      4'h5, 4'h6: tb = 1;
      4'h7, 4'h8, 4'h9: begin
        if (op == 4'h9) r = m_acc ^ lit;
        zw = 1;
        m_zero = (r == 0);
        if (op == 4'h8) mw = 1;
        else m_acc = r;
      end
      default: ;
    endcase
    @(negedge i_ref_clk);
    chk(o_acc, 16'(m_acc));
    chk(o_zero, 16'(m_zero));
    chk(o_zero_we, 16'(zw));
    chk(o_mem_we, 16'(mw));
    if (mw) chk(o_mem_wdata, 16'(r));
    chk(o_flush, 16'(sk));
    chk(o_rom_rd, 16'(tb));
    chk(o_ready, 16'(!(sk || tb)));
    if (tb) begin
      chk(o_rom_addr, 16'({(op == 4'h6) ? MSX_LAST_PAGE : pg, pt}));
      i_rom_data = w;
      @(negedge i_ref_clk);
      chk(o_mem_we, 16'h0001);
      chk(o_mem_wdata, 16'(w[7:0]));
      chk(o_table_high_byte_reg, 16'(w[13:8]));
      i_rom_data = ~w;
    end else if (sk) begin
      // offer a stray xor during the dummy cycle; it must be ignored
      i_instr = '{OP_XOR_IMMEDIATE, d, b, 8'hFF};
      @(negedge i_ref_clk);
      chk(o_flush, 16'h0000);
      chk(o_zero_we, 16'h0000);
    end
    if (sk || tb) begin
      chk(o_ready, 16'h0001);
      chk(o_rom_rd, 16'h0000);
      chk(o_acc, 16'(m_acc));
      chk(o_zero, 16'(m_zero));
    end
  endtask : run

  // main sequence
  initial begin
    void'($urandom(32'h94b5f5db));
    repeat (8) @(negedge i_ref_clk);
    chk(o_acc, 16'h0000);
    chk(o_ready, 16'h0001);
    chk(o_table_high_byte_reg, 16'h0000);
    i_rst = 1'b0;
    $display("test reset done");
    run(4'h1, 8'hA5, 3'h0, 8'h00);
    run(4'h2, 8'h00, 3'h0, 8'h00);
    run(4'h2, 8'h01, 3'h0, 8'h00);
    run(4'h3, 8'h00, 3'h0, 8'h00);
    run(4'h3, 8'h3C, 3'h0, 8'h00);
    for (int b = 0; b < 8; b++) begin
      run(4'h4, 8'h01 << b, 3'(b), 8'h00);
      run(4'h4, ~(8'h01 << b), 3'(b), 8'h00);
    end
    run(4'h5, 8'h00, 3'h0, 8'h00);
    run(4'h6, 8'h00, 3'h0, 8'h00);
    run(4'h9, 8'h00, 3'h0, 8'(m_acc));
    run(4'h7, 8'h5A, 3'h0, 8'h00);
    run(4'h8, 8'h5A, 3'h0, 8'h00);
    run(4'hA, 8'h12, 3'h0, 8'h34);
    run(4'hF, 8'h00, 3'h0, 8'h00);
    $display("test directed done");
    repeat (300) begin
      run(4'($urandom), ($urandom_range(3) == 0) ? 8'(m_acc) : 8'($urandom),
          3'($urandom), 8'($urandom));
    end
    $display("test random done");
    // second reset in mid-run clears the architectural state
    i_rst = 1'b1;
    @(negedge i_ref_clk);
    i_issue = 1'b0;
    @(negedge i_ref_clk);
    chk(o_acc, 16'h0000);
    chk(o_zero, 16'h0000);
    chk(o_ready, 16'h0001);
    chk(o_flush, 16'h0000);
    chk(o_table_high_byte_reg, 16'h0000);
    chk(o_rom_addr, 16'h0000);
    i_rst = 1'b0;
    m_acc = 0;
    m_zero = 0;
    run(4'h7, 8'hC3, 3'h0, 8'h00);
    $display("test rereset done");
    close_out();
  end
endmodule : test_mcu_swap_skip_tblrd_xor_exec
`default_nettype wire
